// ---- inc/ccdiv_defs.svh ----
/*
  Offsets, field positions, reset values and cycle figures of the channel
  clock divider. Included by the design modules and by the property checker.
*/
`ifndef CCDIV_DEFS_SVH
`define CCDIV_DEFS_SVH

// Register indices; the byte address is four times the index
`define CCDIV_IDX_COUNTS 12'h190
`define CCDIV_IDX_CTRL 12'h191
`define CCDIV_IDX_ROUTE 12'h192
`define CCDIV_IDX_SRCSEL 12'h1e1
`define CCDIV_IDX_STATUS 12'h1f0

// Cycle-count register fields
`define CCDIV_LOW_MSB 7
`define CCDIV_LOW_LSB 4
`define CCDIV_HIGH_MSB 3
`define CCDIV_HIGH_LSB 0

// Control register fields
`define CCDIV_BYPASS_BIT 7
`define CCDIV_NOSYNC_BIT 6
`define CCDIV_FORCE_BIT 5
`define CCDIV_START_BIT 4
`define CCDIV_PHASE_MSB 3
`define CCDIV_PHASE_LSB 0

// Routing register fields
`define CCDIV_DIRECT_BIT 1
`define CCDIV_DCCOFF_BIT 0

// Source select codes
`define CCDIV_SEL_OSC 2'b10
`define CCDIV_SEL_CLKIN 2'b00

// Reset values
`define CCDIV_RST_COUNTS 8'h00
`define CCDIV_RST_CTRL 8'h80
`define CCDIV_RST_ROUTE 8'h00
`define CCDIV_RST_SRCSEL 2'b00

// Bus figures
`define CCDIV_HTRANS_NONSEQ 2'b10
`define CCDIV_READ_WAITS 1

`endif

// ---- inc/ccdiv_pkg.sv ----
/*
  Types shared by the divider top and its counting core.
  Stands alone; it does not include ccdiv_defs.svh.
*/
`default_nettype none
package ccdiv_pkg;

  typedef struct packed {
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
    logic start_high;
    logic [3:0] phase_offset;
  } ccdiv_cfg_t;

  typedef enum logic [1:0] {
    CCDIV_HOLD,
    CCDIV_OFFSET,
    CCDIV_RUN
  } ccdiv_state_t;

  typedef struct packed {
    logic [9:0] index;
    logic write;
    logic valid;
  } ccdiv_req_t;

endpackage
`default_nettype wire

// ---- logic/ccdiv_core.sv ----
/*
  Counting core of the channel clock divider: phase offset, then low and
  high phases counted in steps of the selected input clock.
  Assumes one step pulse per rising edge of that input, on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccdiv_defs.svh"

module ccdiv_core (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic step,
  input wire logic hold,
  input wire ccdiv_pkg::ccdiv_cfg_t cfg,
  // Result
  output logic div_out
);
  import ccdiv_pkg::*;

  ccdiv_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic [3:0] limit;

  assign div_out = out_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    out_d = out_q;
    limit = out_q ? cfg.high_cycles : cfg.low_cycles;
    case (state_q)
      CCDIV_HOLD: begin
        out_d = cfg.start_high;
        cnt_d = 4'h0;
        if (!hold) begin
          state_d = (cfg.phase_offset == 4'h0) ? CCDIV_RUN : CCDIV_OFFSET;
        end
      end
      CCDIV_OFFSET: begin
        if (step) begin
          if (cnt_q == cfg.phase_offset - 4'h1) begin
            state_d = CCDIV_RUN;
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      CCDIV_RUN: begin
        if (step) begin
          if (cnt_q >= limit) begin
            out_d = !out_q;
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = CCDIV_HOLD;
      end
    endcase
    if (hold) begin
      state_d = CCDIV_HOLD;
      out_d = cfg.start_high;
      cnt_d = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CCDIV_HOLD;
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

endmodule
`default_nettype wire

// ---- logic/ccdiv_top.sv ----
/*
  Channel clock divider with its AHB-Lite register slave, source
  synchronisers and output routing for the first output pair.
  Assumes osc_in, clk_in and chip_sync are pins, sampled on hclk, and
  that hclk runs well above the source frequencies.
  Register writes apply at once; the core reads them each hclk, the cycle counts only on a step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccdiv_defs.svh"

module ccdiv_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock sources and chip sync pins
  input wire logic osc_in,
  input wire logic clk_in,
  input wire logic chip_sync,
  // First output pair
  output logic pair_a_first_output,
  output logic pair_a_second_output
);
  import ccdiv_pkg::*;

  // Registers
  logic [7:0] counts_q, counts_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] route_q, route_d;
  logic [1:0] srcsel_q, srcsel_d;
  logic osc_route_q, osc_route_d;

  // Bus state
  ccdiv_req_t req_q, req_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic rd_wait_q, rd_wait_d;
  logic hresp_q, hresp_d;

  // Synchronisers
  logic osc_s1_q, osc_s2_q;
  logic osc_s1_d, osc_s2_d;
  logic clk_s1_q, clk_s2_q;
  logic clk_s1_d, clk_s2_d;
  logic sync_s1_q, sync_s2_q;
  logic sync_s1_d, sync_s2_d;
  logic src_prev_q, src_prev_d;

  // Outputs
  logic first_q, first_d;
  logic second_q, second_d;

  // Derived
  logic src_level;
  logic step;
  logic bypass;
  logic nosync;
  logic force_high;
  logic forced;
  logic hold;
  logic div_level;
  logic out_level;
  logic take;
  logic rd_start;
  logic direct;
  logic [3:0] status;
  ccdiv_cfg_t cfg;

  function automatic logic [9:0] word_index(input logic [31:0] addr);
    word_index = addr[11:2];
  endfunction

  function automatic logic [31:0] read_mux(
    input logic [9:0] idx,
    input logic [7:0] counts,
    input logic [7:0] ctrl,
    input logic [7:0] route,
    input logic [1:0] srcsel,
    input logic [3:0] status
  );
    read_mux = 32'h0000_0000;
    case (idx)
      10'(`CCDIV_IDX_COUNTS): read_mux = {24'h00_0000, counts};
      10'(`CCDIV_IDX_CTRL): read_mux = {24'h00_0000, ctrl};
      10'(`CCDIV_IDX_ROUTE): read_mux = {24'h00_0000, route};
      10'(`CCDIV_IDX_SRCSEL): read_mux = {30'h0000_0000, srcsel};
      10'(`CCDIV_IDX_STATUS): read_mux = {28'h000_0000, status};
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign pair_a_first_output = first_q;
  assign pair_a_second_output = second_q;

  // Field views
  assign bypass = ctrl_q[`CCDIV_BYPASS_BIT];
  assign nosync = ctrl_q[`CCDIV_NOSYNC_BIT];
  assign force_high = ctrl_q[`CCDIV_FORCE_BIT];
  assign direct = route_q[`CCDIV_DIRECT_BIT];
  assign cfg.low_cycles = counts_q[`CCDIV_LOW_MSB:`CCDIV_LOW_LSB];
  assign cfg.high_cycles = counts_q[`CCDIV_HIGH_MSB:`CCDIV_HIGH_LSB];
  assign cfg.start_high = ctrl_q[`CCDIV_START_BIT];
  assign cfg.phase_offset = ctrl_q[`CCDIV_PHASE_MSB:`CCDIV_PHASE_LSB];

  // Source selection and step detect on the second sync stage only
  assign src_level = osc_route_q ? osc_s2_q : clk_s2_q;
  assign step = src_level && !src_prev_q;
  // Switching sources may add one stray step; only that phase shortens

  // Force needs sync-ignore set and loses to bypass
  assign forced = nosync && force_high && !bypass;
  // Divider idles under bypass and under an obeyed sync
  assign hold = bypass || (sync_s2_q && !nosync) || forced;

  // Core only counts; bypass, force and routing stay out here
  ccdiv_core i_ccdiv_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .step(step),
    .hold(hold),
    .cfg(cfg),
    .div_out(div_level)
  );

  always_comb begin
    if (bypass) begin
      out_level = src_level;
    end else if (forced) begin
      out_level = 1'b1;
    end else begin
      out_level = div_level;
    end
  end

  // Output routing; both outputs of the pair switch on the same edge
  always_comb begin
    if (direct) begin
      first_d = src_level;
    end else begin
      first_d = out_level;
    end
    second_d = first_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
    end else begin
      first_q <= first_d;
      second_q <= second_d;
    end
  end

  // Pin synchronisers; nothing but the second stage reads the first
  always_comb begin
    osc_s1_d = osc_in;
    osc_s2_d = osc_s1_q;
    clk_s1_d = clk_in;
    clk_s2_d = clk_s1_q;
    sync_s1_d = chip_sync;
    sync_s2_d = sync_s1_q;
    src_prev_d = src_level;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_s1_d;
      osc_s2_q <= osc_s2_d;
      clk_s1_q <= clk_s1_d;
      clk_s2_q <= clk_s2_d;
      sync_s1_q <= sync_s1_d;
      sync_s2_q <= sync_s2_d;
      src_prev_q <= src_prev_d;
    end
  end

  // Source latch: only the two defined codes move it
  always_comb begin
    osc_route_d = osc_route_q;
    if (srcsel_q == `CCDIV_SEL_OSC) begin
      osc_route_d = 1'b1;
    end else if (srcsel_q == `CCDIV_SEL_CLKIN) begin
      osc_route_d = 1'b0;
    end
  end

  // Bus: writes take no wait, reads one wait state
  // hsize is not decoded; every register is one whole word
  assign take = hsel && hready && htrans[1];
  assign rd_start = take && !hwrite;
  // Status: synced sync, oscillator routed, first output, output level before routing
  assign status = {sync_s2_q, osc_route_q, first_q, out_level};

  always_comb begin
    req_d = req_q;
    rd_wait_d = 1'b0;
    hreadyout_d = 1'b1;
    // OKAY only: no access can fault
    hresp_d = 1'b0;
    hrdata_d = hrdata_q;
    counts_d = counts_q;
    ctrl_d = ctrl_q;
    route_d = route_q;
    srcsel_d = srcsel_q;
    // Writes land in the data phase, the only cycle hwdata is valid
    if (req_q.valid && req_q.write) begin
      case (req_q.index)
        10'(`CCDIV_IDX_COUNTS): counts_d = hwdata[7:0];
        10'(`CCDIV_IDX_CTRL): ctrl_d = hwdata[7:0];
        10'(`CCDIV_IDX_ROUTE): route_d = hwdata[7:0];
        10'(`CCDIV_IDX_SRCSEL): srcsel_d = hwdata[1:0];
        default: begin
        end
      endcase
    end
    // Read data on a flop costs one wait state
    if (rd_wait_q) begin
      hrdata_d = read_mux(req_q.index, counts_q, ctrl_q, route_q, srcsel_q, status);
    end
    // A stalled read frees its request once the data is loaded
    if (hready || rd_wait_q) begin
      req_d.valid = 1'b0;
    end
    if (take) begin
      req_d.index = word_index(haddr);
      req_d.write = hwrite;
      req_d.valid = 1'b1;
      if (rd_start) begin
        rd_wait_d = 1'b1;
        hreadyout_d = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      rd_wait_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      req_q <= req_d;
      rd_wait_q <= rd_wait_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counts_q <= `CCDIV_RST_COUNTS;
      // Bypass from reset: the output follows the source before setup
      ctrl_q <= `CCDIV_RST_CTRL;
      route_q <= `CCDIV_RST_ROUTE;
      srcsel_q <= `CCDIV_RST_SRCSEL;
      osc_route_q <= 1'b0;
    end else begin
      counts_q <= counts_d;
      ctrl_q <= ctrl_d;
      route_q <= route_d;
      srcsel_q <= srcsel_d;
      osc_route_q <= osc_route_d;
    end
  end

endmodule
`default_nettype wire

// ---- dv/ccdiv_properties.sv ----
/*
  Bus and output-pair checks on the divider top ports.
  Assumes hready is the slave's own hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccdiv_defs.svh"
module ccdiv_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Output pair
  input wire logic pair_a_first_output,
  input wire logic pair_a_second_output
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && hready && htrans[1];
  sequence s_rd_req;
    take && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd_req |=> s_rd_ans;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_fell_cause;
    $fell(hreadyout) |-> $past(take && !hwrite);
  endproperty
  a_fell_cause: assert property (p_fell_cause) else $error("stall without read");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_hold_data;
    !$rose(hreadyout) |-> $stable(hrdata);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("read data moved");
  property p_upper_zero;
    $rose(hreadyout) |-> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_unmapped;
    s_rd_req and !(haddr[11:2] inside {`CCDIV_IDX_COUNTS, `CCDIV_IDX_CTRL,
      `CCDIV_IDX_ROUTE, `CCDIV_IDX_SRCSEL, `CCDIV_IDX_STATUS}) |-> ##2 hrdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pair_copy;
    pair_a_second_output == pair_a_first_output;
  endproperty
  a_pair_copy: assert property (p_pair_copy) else $error("pair copy wrong");
endmodule
bind ccdiv_top ccdiv_properties i_ccdiv_properties (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pair_a_first_output(pair_a_first_output), .pair_a_second_output(pair_a_second_output));
`default_nettype wire

// ---- dv/ccdiv_tb.sv ----
/*
  Self-checking bench: register rows, then divider, bypass, force,
  sync and routing cases. Assumes sources are slow waves made on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ccdiv_tb;
  import ccdiv_pkg::*;
  typedef struct packed {
    logic [9:0] idx;
    logic wr;
    logic [7:0] d;
    logic [7:0] exp;
  } ccdiv_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic hreadyout;
  logic hresp;
  logic first_out;
  logic second_out;
  logic osc_in = 1'b0;
  logic clk_in = 1'b0;
  logic chip_sync = 1'b0;
  logic [7:0] src_q = 8'h00;
  int error_cnt = 0;
  int comparisons = 0;
  int hi;
  int lo;
  int t0;
  int t1;
  ccdiv_row_t rows [14] = '{'{10'h190, 1'b0, 8'h00, 8'h00}, '{10'h191, 1'b0, 8'h00, 8'h80},
    '{10'h192, 1'b0, 8'h00, 8'h00}, '{10'h1e1, 1'b0, 8'h00, 8'h00},
    '{10'h191, 1'b1, 8'h5f, 8'h00}, '{10'h191, 1'b0, 8'h00, 8'h5f},
    '{10'h192, 1'b1, 8'h03, 8'h00}, '{10'h192, 1'b0, 8'h00, 8'h03},
    '{10'h1e1, 1'b1, 8'h02, 8'h00}, '{10'h1e1, 1'b0, 8'h00, 8'h02},
    '{10'h100, 1'b1, 8'hff, 8'h00}, '{10'h100, 1'b0, 8'h00, 8'h00},
    '{10'h190, 1'b1, 8'h21, 8'h00}, '{10'h190, 1'b0, 8'h00, 8'h21}};

  always #2.5 hclk = ~hclk;
  // Clock input: 8-cycle period; oscillator: 4-cycle period
  always @(posedge hclk) begin
    src_q <= src_q + 8'h01;
    clk_in <= src_q[2];
    osc_in <= src_q[1];
  end

  ccdiv_top i_ccdiv_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_in(osc_in),
    .clk_in(clk_in), .chip_sync(chip_sync), .pair_a_first_output(first_out),
    .pair_a_second_output(second_out));

  task summarize;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] q);
    haddr <= {20'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // Full high run then full low run, in hclk cycles; zeros if static
  task runs(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (first_out !== 1'b0 && n < 200) begin @(posedge hclk); n++; end
    while (first_out !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
    while (first_out === 1'b1 && n < 200) begin @(posedge hclk); n++; h++; end
    while (first_out === 1'b0 && n < 200) begin @(posedge hclk); n++; l++; end
    if (n >= 200) begin
      h = 0;
      l = 0;
    end
  endtask

  task dcase(input logic [7:0] c, input logic [7:0] r, input logic [7:0] s,
             input int h, input int l);
    bus(1'b1, 10'h191, c, rv);
    bus(1'b1, 10'h192, r, rv);
    bus(1'b1, 10'h1e1, s, rv);
    repeat (40) @(posedge hclk);
    runs(hi, lo);
    chk("high run", h, hi);
    chk("low run", l, lo);
  endtask

  // Release an obeyed sync at a fixed source phase; cycles to first rise
  task offs(input logic [7:0] c, output int t);
    chip_sync <= 1'b1;
    bus(1'b1, 10'h191, c, rv);
    repeat (8) @(posedge hclk);
    while (src_q[2:0] != 3'h0) @(posedge hclk);
    chip_sync <= 1'b0;
    t = 0;
    while (first_out !== 1'b1 && t < 200) begin @(posedge hclk); t++; end
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].idx, rows[i].d, rv);
      if (!rows[i].wr) chk("register", {24'h00_0000, rows[i].exp}, rv);
    end
    dcase(8'h00, 8'h00, 8'h00, 16, 24);
    dcase(8'h80, 8'h00, 8'h00, 4, 4);
    dcase(8'he0, 8'h00, 8'h00, 4, 4);
    dcase(8'h60, 8'h00, 8'h00, 0, 0);
    chk("forced level", 1, first_out);
    chip_sync <= 1'b1;
    dcase(8'h10, 8'h00, 8'h00, 0, 0);
    chk("sync start high", 1, first_out);
    dcase(8'h00, 8'h00, 8'h00, 0, 0);
    chk("sync start low", 0, first_out);
    dcase(8'h40, 8'h00, 8'h00, 16, 24);
    offs(8'h00, t0);
    offs(8'h02, t1);
    chk("offset delay", 32'h0000_0010, t1 - t0);
    chip_sync <= 1'b0;
    dcase(8'h00, 8'h02, 8'h00, 4, 4);
    dcase(8'h00, 8'h02, 8'h02, 2, 2);
    dcase(8'h00, 8'h02, 8'h01, 2, 2);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 10'h191, 8'h00, rv);
    chk("control after reset", 32'h0000_0080, rv);
    summarize();
  end

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
